// >>> gam_defs.svh
// address map and timing constants of the gateway map and status lamps
// assumes inclusion by bare name from the design modules only
`ifndef GAM_DEFS_SVH
`define GAM_DEFS_SVH

// ************************************************************
// address map
// ************************************************************
`define GAM_WORDS          750
`define GAM_LAST_WORD      10'h2ED
`define GAM_LAST_BIT_WORD  12'h2ED
`define GAM_HOLD_IN_BASE   16'h0800
`define GAM_HOLD_IN_LAST   16'h0AED
`define GAM_IDLE_ADDR      16'h1004
`define GAM_IDLE_RESET     16'h0000
`define GAM_IDLE_BIT       0

// ************************************************************
// timing
// ************************************************************
`define GAM_CLK_PERIOD_NS  4
`define GAM_FLASH_HALF_NS  250000000
`define GAM_FLASH_HALF_CYC (`GAM_FLASH_HALF_NS / `GAM_CLK_PERIOD_NS)

`endif

// >>> gam_pkg.sv
// types shared by the gateway map and status lamp logic
// assumes nothing of its surroundings
package gam_pkg;

    // ************************************************************
    // network address spaces, one-hot
    // ************************************************************
    typedef enum logic [3:0] {
        GAM_COIL  = 4'h1,  // client-written bits
        GAM_DISC  = 4'h2,  // subnetwork-written bits
        GAM_INREG = 4'h4,  // subnetwork-written words
        GAM_HOLD  = 4'h8   // holding registers
    } gam_space_type;

    // ************************************************************
    // lamp display modes, one-hot
    // ************************************************************
    typedef enum logic [4:0] {
        GAM_OFF      = 5'h01,
        GAM_ON_A     = 5'h02,  // steady first colour
        GAM_FLASH_A  = 5'h04,  // flashing first colour
        GAM_ON_B     = 5'h08,  // steady second colour
        GAM_FLASH_B  = 5'h10   // flashing second colour
    } gam_lamp_type;

endpackage : gam_pkg

// >>> gam_flash.sv
// common flash phase generator for all flashing lamps
// assumes one clock, synchronous active-low reset and a clock enable
`timescale 1ns/100ps
`include "gam_defs.svh"

module gam_flash #(
    parameter int unsigned HALF_CYCLES = `GAM_FLASH_HALF_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    output logic      phase
);

    // ************************************************************
    // half-period counter and phase
    // ************************************************************
    logic [31:0] cnt_reg;    // cycles spent in this half
    logic [31:0] cnt_next;
    logic        phase_reg;  // lamp lit while high
    logic        phase_next;

    // count a half period, then toggle the phase
    always_comb begin
        cnt_next   = cnt_reg;
        phase_next = phase_reg;
        if (ce) begin
            if (cnt_reg >= HALF_CYCLES - 1) begin
                cnt_next   = 32'h0000_0000;
                phase_next = ~phase_reg;
            end else begin
                cnt_next = cnt_reg + 32'h0000_0001;
            end
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg   <= 32'h0000_0000;
            phase_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;

    flash_bound_a: assert property (@(posedge clk) disable iff (!rstn)
        cnt_reg < HALF_CYCLES) else $error("flash counter overran its half period");

endmodule : gam_flash

// >>> gam_gateway.sv
// gateway process-data address map, idle register and status lamp encoding
// assumes the client request port and subnetwork port are in the clk domain;
// ethernet link pins come from the phy and are synchronised here
//
// Behaviour
// - client data words map to coils and holding regs
// - subnet words map to inputs, input regs, holding 0x0800+
// - client writes 0x1004 to enter or leave idle
// - server lamp flashes green online, steady after message
// - server red conflict/fatal, flash timeout, off otherwise
// - subnet lamp green running, flashing if some offline
// - subnet lamp flash red all offline, red fatal
// - security lamp green when locked and no exception or fatal error, else off
// - link lamp green at 100M, flashing on activity
// - link lamp yellow at 10M, flashing on activity
`timescale 1ns/100ps
`include "gam_defs.svh"

module gam_gateway #(
    parameter int unsigned WORDS       = `GAM_WORDS,
    parameter int unsigned FLASH_HALF  = `GAM_FLASH_HALF_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  req_valid,
    input  wire logic                  req_write,
    input  wire gam_pkg::gam_space_type req_space,
    input  wire logic [15:0]           req_addr,
    input  wire logic [15:0]           req_wdata,
    output logic                       rsp_valid,
    output logic [15:0]                rsp_rdata,
    output logic                       rsp_error,
    input  wire logic [9:0]            sub_rd_idx,
    output logic [15:0]                sub_rd_data,
    input  wire logic                  sub_wr_en,
    input  wire logic [9:0]            sub_wr_idx,
    input  wire logic [15:0]           sub_wr_data,
    output logic                       idle_mode,
    input  wire logic                  net_online,
    input  wire logic                  ip_present,
    input  wire logic                  ip_conflict,
    input  wire logic                  conn_timeout,
    input  wire logic                  exception,
    input  wire logic                  fatal_error,
    input  wire logic                  sub_running,
    input  wire logic                  nodes_some_offline,
    input  wire logic                  nodes_all_offline,
    input  wire logic                  sec_locked,
    input  wire logic                  link_up_pin,
    input  wire logic                  link_fast_pin,
    input  wire logic                  link_act_pin,
    output logic                       second_status_lamp_green,
    output logic                       second_status_lamp_red,
    output logic                       third_status_lamp_green,
    output logic                       third_status_lamp_red,
    output logic                       fourth_status_lamp_green,
    output logic                       link_lamp_green,
    output logic                       link_lamp_yellow
);

    // ************************************************************
    // helpers
    // ************************************************************
    // word address inside the process-data window
    function automatic logic word_ok(input logic [15:0] a);
        word_ok = (a <= {6'h00, `GAM_LAST_WORD});
    endfunction : word_ok

    // bit address inside the process-data window
    function automatic logic bit_ok(input logic [15:0] a);
        bit_ok = (a[15:4] <= `GAM_LAST_BIT_WORD);
    endfunction : bit_ok

    // lamp drive for the first and second colour from mode and flash phase
    function automatic logic [1:0] lamp_drive(input gam_pkg::gam_lamp_type m,
                                              input logic ph);
        case (m)
            gam_pkg::GAM_ON_A:    lamp_drive = 2'h1;
            gam_pkg::GAM_FLASH_A: lamp_drive = {1'b0, ph};
            gam_pkg::GAM_ON_B:    lamp_drive = 2'h2;
            gam_pkg::GAM_FLASH_B: lamp_drive = {ph, 1'b0};
            default:              lamp_drive = 2'h0;
        endcase
    endfunction : lamp_drive

    // ************************************************************
    // process-data memories
    // ************************************************************
    logic [15:0] out_mem [WORDS];  // client toward subnetwork
    logic [15:0] in_mem  [WORDS];  // subnetwork toward client

    // ************************************************************
    // request decode
    // ************************************************************
    logic        take;      // request accepted this cycle
    logic        hit;       // address is mapped
    logic        is_bit;    // single-bit access
    logic        src_out;   // addresses the client-written words
    logic        is_idle;   // addresses the idle register
    logic        ro;        // read-only target
    logic [9:0]  idx;       // word index
    logic [15:0] word_val;  // addressed word
    logic [15:0] new_word;  // word after a write
    logic        out_we;    // write to client-written words
    logic [15:0] hold_off;  // offset into the mirrored words

    assign take     = ce & req_valid;
    assign hold_off = req_addr - `GAM_HOLD_IN_BASE;

    // address decoding per space
    always_comb begin
        hit     = 1'b0;
        is_bit  = 1'b0;
        src_out = 1'b0;
        is_idle = 1'b0;
        ro      = 1'b0;
        idx     = req_addr[9:0];
        if (req_space == gam_pkg::GAM_COIL) begin
            hit     = bit_ok(req_addr);
            is_bit  = 1'b1;
            src_out = 1'b1;
            idx     = req_addr[13:4];
        end else if (req_space == gam_pkg::GAM_DISC) begin
            hit    = bit_ok(req_addr);
            is_bit = 1'b1;
            ro     = 1'b1;
            idx    = req_addr[13:4];
        end else if (req_space == gam_pkg::GAM_INREG) begin
            hit = word_ok(req_addr);
            ro  = 1'b1;
        end else if (req_space == gam_pkg::GAM_HOLD) begin
            if (word_ok(req_addr)) begin
                hit     = 1'b1;
                src_out = 1'b1;
            end else if (req_addr >= `GAM_HOLD_IN_BASE && req_addr <= `GAM_HOLD_IN_LAST) begin
                hit = 1'b1;
                ro  = 1'b1;
                idx = hold_off[9:0];
            end else if (req_addr == `GAM_IDLE_ADDR) begin
                hit     = 1'b1;
                is_idle = 1'b1;
            end
        end
    end

    // addressed word and its updated value
    always_comb begin
        word_val = 16'h0000;
        if (hit && !is_idle) begin
            word_val = src_out ? out_mem[idx] : in_mem[idx];
        end
        new_word = req_wdata;
        if (is_bit) begin
            new_word          = word_val;
            new_word[req_addr[3:0]] = req_wdata[0];  // coil write keeps other bits
        end
    end

    assign out_we = take & req_write & hit & src_out;

    // memory writes: client words from requests, subnet words from subnet port
    always_ff @(posedge clk) begin
        if (out_we) begin
            out_mem[idx] <= new_word;
        end
        if (ce && sub_wr_en && sub_wr_idx <= `GAM_LAST_WORD) begin
            in_mem[sub_wr_idx] <= sub_wr_data;
        end
    end

    // ************************************************************
    // answer, idle register, subnetwork read port, message seen
    // ************************************************************
    logic        rsp_valid_reg, rsp_valid_next;
    logic [15:0] rsp_rdata_reg, rsp_rdata_next;
    logic        rsp_error_reg, rsp_error_next;
    logic [15:0] idle_reg,      idle_next;      // idle_mode_control
    logic [15:0] sub_rd_reg,    sub_rd_next;
    logic        msg_seen_reg,  msg_seen_next;  // a request arrived while online

    // next values of the answer path
    always_comb begin
        rsp_valid_next = rsp_valid_reg;
        rsp_rdata_next = rsp_rdata_reg;
        rsp_error_next = rsp_error_reg;
        idle_next      = idle_reg;
        sub_rd_next    = sub_rd_reg;
        msg_seen_next  = msg_seen_reg;
        if (ce) begin
            rsp_valid_next = take;
            sub_rd_next    = (sub_rd_idx <= `GAM_LAST_WORD) ? out_mem[sub_rd_idx] : 16'h0000;
            msg_seen_next  = net_online & (msg_seen_reg | req_valid);
            if (take) begin
                rsp_error_next = ~hit | (req_write & ro);
                if (is_idle) begin
                    rsp_rdata_next = idle_reg;
                end else if (is_bit) begin
                    rsp_rdata_next = {15'h0000, word_val[req_addr[3:0]]};
                end else begin
                    rsp_rdata_next = word_val;
                end
                if (req_write && is_idle) begin
                    idle_next = req_wdata;
                end
            end
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 16'h0000;
            rsp_error_reg <= 1'b0;
            idle_reg      <= `GAM_IDLE_RESET;
            sub_rd_reg    <= 16'h0000;
            msg_seen_reg  <= 1'b0;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            rsp_error_reg <= rsp_error_next;
            idle_reg      <= idle_next;
            sub_rd_reg    <= sub_rd_next;
            msg_seen_reg  <= msg_seen_next;
        end
    end

    assign rsp_valid   = rsp_valid_reg;
    assign rsp_rdata   = rsp_rdata_reg;
    assign rsp_error   = rsp_error_reg;
    assign sub_rd_data = sub_rd_reg;
    assign idle_mode   = idle_reg[`GAM_IDLE_BIT];

    // ************************************************************
    // link pin synchronisers
    // ************************************************************
    logic [2:0] link_meta_reg, link_meta_next;  // first stage
    logic [2:0] link_sync_reg, link_sync_next;  // second stage: up, fast, act

    // two flops per pin
    always_comb begin
        link_meta_next = link_meta_reg;
        link_sync_next = link_sync_reg;
        if (ce) begin
            link_meta_next = {link_act_pin, link_fast_pin, link_up_pin};
            link_sync_next = link_meta_reg;
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            link_meta_reg <= 3'h0;
            link_sync_reg <= 3'h0;
        end else begin
            link_meta_reg <= link_meta_next;
            link_sync_reg <= link_sync_next;
        end
    end

    // ************************************************************
    // lamp modes and drive
    // ************************************************************
    logic                 flash_phase;
    gam_pkg::gam_lamp_type srv_mode, sub_mode, sec_mode, lnk_mode;
    logic [6:0]           lamp_reg, lamp_next;  // registered lamp outputs

    gam_flash #(
        .HALF_CYCLES (FLASH_HALF)
    ) u_flash (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .phase (flash_phase)
    );

    // mode of each lamp from status, highest priority first
    always_comb begin
        // server lamp: a is green, b is red
        if (exception || !ip_present) begin
            srv_mode = gam_pkg::GAM_OFF;
        end else if (ip_conflict || fatal_error) begin
            srv_mode = gam_pkg::GAM_ON_B;
        end else if (conn_timeout) begin
            srv_mode = gam_pkg::GAM_FLASH_B;
        end else if (net_online && msg_seen_reg) begin
            srv_mode = gam_pkg::GAM_ON_A;
        end else if (net_online) begin
            srv_mode = gam_pkg::GAM_FLASH_A;
        end else begin
            srv_mode = gam_pkg::GAM_OFF;
        end
        // subnetwork lamp: a is green, b is red
        if (exception) begin
            sub_mode = gam_pkg::GAM_OFF;
        end else if (fatal_error) begin
            sub_mode = gam_pkg::GAM_ON_B;
        end else if (!sub_running) begin
            sub_mode = gam_pkg::GAM_OFF;
        end else if (nodes_all_offline) begin
            sub_mode = gam_pkg::GAM_FLASH_B;
        end else if (nodes_some_offline) begin
            sub_mode = gam_pkg::GAM_FLASH_A;
        end else begin
            sub_mode = gam_pkg::GAM_ON_A;
        end
        // security lamp: green only
        if (sec_locked && !exception && !fatal_error) begin
            sec_mode = gam_pkg::GAM_ON_A;
        end else begin
            sec_mode = gam_pkg::GAM_OFF;
        end
        // link lamp: a is green at 100M, b is yellow at 10M
        if (!link_sync_reg[0]) begin
            lnk_mode = gam_pkg::GAM_OFF;
        end else if (link_sync_reg[1]) begin
            lnk_mode = link_sync_reg[2] ? gam_pkg::GAM_FLASH_A : gam_pkg::GAM_ON_A;
        end else begin
            lnk_mode = link_sync_reg[2] ? gam_pkg::GAM_FLASH_B : gam_pkg::GAM_ON_B;
        end
    end

    // lamp drive values, shared flash phase for every flashing lamp
    always_comb begin
        lamp_next = lamp_reg;
        if (ce) begin
            lamp_next[1:0] = lamp_drive(srv_mode, flash_phase);
            lamp_next[3:2] = lamp_drive(sub_mode, flash_phase);
            lamp_next[4]   = lamp_drive(sec_mode, flash_phase) == 2'h1;
            lamp_next[6:5] = lamp_drive(lnk_mode, flash_phase);
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lamp_reg <= 7'h00;
        end else begin
            lamp_reg <= lamp_next;
        end
    end

    assign second_status_lamp_green = lamp_reg[0];
    assign second_status_lamp_red   = lamp_reg[1];
    assign third_status_lamp_green  = lamp_reg[2];
    assign third_status_lamp_red    = lamp_reg[3];
    assign fourth_status_lamp_green = lamp_reg[4];
    assign link_lamp_green          = lamp_reg[5];
    assign link_lamp_yellow         = lamp_reg[6];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    coil_read_a: assert property (take && !req_write && req_space == gam_pkg::GAM_COIL
        && bit_ok(req_addr) |=> rsp_valid && !rsp_error
        && rsp_rdata == {15'h0000, $past(word_val[req_addr[3:0]])})
        else $error("coil read returned the wrong bit");
    hold_write_a: assert property (take && req_write && req_space == gam_pkg::GAM_HOLD
        && word_ok(req_addr) |=> !rsp_error) else $error("holding write refused");
    inreg_read_a: assert property (take && !req_write && req_space == gam_pkg::GAM_INREG
        && word_ok(req_addr) |=> rsp_rdata == $past(word_val) && !rsp_error)
        else $error("input register read wrong");
    mirror_ro_a: assert property (take && req_write && req_space == gam_pkg::GAM_HOLD
        && req_addr >= `GAM_HOLD_IN_BASE && req_addr <= `GAM_HOLD_IN_LAST |=> rsp_error)
        else $error("write to mirrored words not refused");
    idle_track_a: assert property (take && req_write && req_space == gam_pkg::GAM_HOLD
        && req_addr == `GAM_IDLE_ADDR |=> idle_mode == $past(req_wdata[`GAM_IDLE_BIT]))
        else $error("idle state did not follow the write");
    srv_green_a: assert property (ce && net_online && msg_seen_reg && ip_present && !exception
        && !ip_conflict && !fatal_error && !conn_timeout
        |=> second_status_lamp_green && !second_status_lamp_red)
        else $error("server lamp not steady green");
    srv_red_a: assert property (ce && ip_present && !exception && (ip_conflict || fatal_error)
        |=> second_status_lamp_red && !second_status_lamp_green)
        else $error("server lamp not steady red");
    sub_green_a: assert property (ce && sub_running && !nodes_some_offline
        && !nodes_all_offline && !exception && !fatal_error |=> third_status_lamp_green)
        else $error("subnet lamp not green");
    sub_off_a: assert property (ce && !sub_running && !fatal_error
        |=> !third_status_lamp_green && !third_status_lamp_red)
        else $error("subnet lamp lit while stopped");
    sec_lamp_a: assert property (ce ##1 ce |-> fourth_status_lamp_green
        == $past(sec_locked && !exception && !fatal_error))
        else $error("security lamp wrong");
    link_fast_a: assert property (ce && link_sync_reg == 3'h3
        |=> link_lamp_green && !link_lamp_yellow) else $error("100M link lamp wrong");
    link_slow_a: assert property (ce && link_sync_reg == 3'h1
        |=> link_lamp_yellow && !link_lamp_green) else $error("10M link lamp wrong");

    coil_write_c: cover property (out_we && req_space == gam_pkg::GAM_COIL);
    idle_write_c: cover property (take && req_write && is_idle ##1 idle_mode);
    srv_steady_c: cover property (second_status_lamp_green [*2]);
    link_flash_c: cover property (link_lamp_green ##1 !link_lamp_green && link_sync_reg[0]);

endmodule : gam_gateway

// >>> gam_client.sv
// network client model: one request at a time on the gateway map port
// assumes the gateway clock; drives at falling edges
`timescale 1ns/100ps
module gam_client (
    input  wire logic                  clk,
    input  wire logic                  rsp_valid,
    input  wire logic [15:0]           rsp_rdata,
    input  wire logic                  rsp_error,
    output logic                       req_valid,
    output logic                       req_write,
    output gam_pkg::gam_space_type     req_space,
    output logic [15:0]                req_addr,
    output logic [15:0]                req_wdata
);
    // idle bus at time zero
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_space = gam_pkg::GAM_HOLD;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
    end

    // request for one edge, wait bounded for the answer, then scramble the bus
    task automatic xfer(input logic w, input gam_pkg::gam_space_type sp,
                        input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output logic ok);
        ok = 1'b0;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = w;
        req_space = sp;
        req_addr  = a;
        req_wdata = d;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            req_valid = 1'b0;
            ok = (rsp_valid === 1'b1);
        end
        q = rsp_rdata;
        e = rsp_error;
        req_addr  = ~a;
        req_wdata = ~d;
    endtask : xfer
endmodule : gam_client

// >>> test_gam_gateway.sv
// self-checking bench for the gateway map, idle register and lamps
// assumes gam_gateway and gam_client; flash half period shortened
`timescale 1ns/100ps
module test_gam_gateway;
    localparam gam_pkg::gam_space_type hold = gam_pkg::GAM_HOLD;
    localparam gam_pkg::gam_space_type coil = gam_pkg::GAM_COIL;
    localparam gam_pkg::gam_space_type disc = gam_pkg::GAM_DISC;
    localparam gam_pkg::gam_space_type inrg = gam_pkg::GAM_INREG;
    logic                   clk = 1'b0;
    logic                   rstn, ce, req_valid, req_write, rsp_valid, rsp_error;
    logic                   sub_wr_en, idle_mode;
    gam_pkg::gam_space_type req_space;
    logic [15:0]            req_addr, req_wdata, rsp_rdata, sub_rd_data, sub_wr_data;
    logic [9:0]             sub_rd_idx, sub_wr_idx;
    logic [12:0]            st;     // status inputs, online first, activity last
    logic [6:0]             lamps;  // server g/r, subnet g/r, security, link g/y
    int                     err_count = 0;
    int                     num_checks = 0;

    always #2 clk = ~clk;

    gam_gateway #(.FLASH_HALF(4)) gam_gateway_i (
        .clk(clk), .rstn(rstn), .ce(ce), .req_valid(req_valid), .req_write(req_write),
        .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
        .sub_rd_idx(sub_rd_idx), .sub_rd_data(sub_rd_data), .sub_wr_en(sub_wr_en),
        .sub_wr_idx(sub_wr_idx), .sub_wr_data(sub_wr_data), .idle_mode(idle_mode),
        .net_online(st[12]), .ip_present(st[11]), .ip_conflict(st[10]),
        .conn_timeout(st[9]), .exception(st[8]), .fatal_error(st[7]),
        .sub_running(st[6]), .nodes_some_offline(st[5]), .nodes_all_offline(st[4]),
        .sec_locked(st[3]), .link_up_pin(st[2]), .link_fast_pin(st[1]),
        .link_act_pin(st[0]), .second_status_lamp_green(lamps[6]),
        .second_status_lamp_red(lamps[5]), .third_status_lamp_green(lamps[4]),
        .third_status_lamp_red(lamps[3]), .fourth_status_lamp_green(lamps[2]),
        .link_lamp_green(lamps[1]), .link_lamp_yellow(lamps[0]));

    gam_client gam_client_i (
        .clk(clk), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
        .req_valid(req_valid), .req_write(req_write), .req_space(req_space),
        .req_addr(req_addr), .req_wdata(req_wdata));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
        num_checks++;
        if (s !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    // one client access; read data judged only on good reads
    task automatic acc(input logic w, input gam_pkg::gam_space_type sp, input logic [15:0] a,
                       input logic [15:0] d, input logic [15:0] xq, input logic xe);
        logic [15:0] q;
        logic        e, ok;
        gam_client_i.xfer(w, sp, a, d, q, e, ok);
        if (!ok) begin
            err_count++;
            end_sim();
        end
        chk("rsp_error", {15'h0000, e}, {15'h0000, xe});
        if (!w && !xe) chk("rsp_rdata", q, xq);
    endtask : acc

    task automatic map_out;
        acc(1'b1, hold, 16'h0001, 16'hA5C3, 16'h0000, 1'b0);
        acc(1'b0, coil, 16'h0010, 16'h0000, 16'h0001, 1'b0);
        acc(1'b1, coil, 16'h0012, 16'h0001, 16'h0000, 1'b0);
        acc(1'b0, hold, 16'h0001, 16'h0000, 16'hA5C7, 1'b0);
        acc(1'b0, coil, 16'h001F, 16'h0000, 16'h0001, 1'b0);
        acc(1'b1, hold, 16'h02ED, 16'h1234, 16'h0000, 1'b0);
        acc(1'b0, coil, 16'h2EDC, 16'h0000, 16'h0001, 1'b0);
        acc(1'b0, coil, 16'h2EE0, 16'h0000, 16'h0000, 1'b1);
        acc(1'b0, hold, 16'h02EE, 16'h0000, 16'h0000, 1'b1);
        sub_rd_idx = 10'h2ED;
        repeat (2) @(negedge clk);
        chk("sub_rd_data", sub_rd_data, 16'h1234);
    endtask : map_out

    task automatic map_in;
        sub_wr_en   = 1'b1;
        sub_wr_idx  = 10'h2ED;
        sub_wr_data = 16'h8001;
        @(negedge clk);
        sub_wr_en = 1'b0;
        acc(1'b0, inrg, 16'h02ED, 16'h0000, 16'h8001, 1'b0);
        acc(1'b0, hold, 16'h0AED, 16'h0000, 16'h8001, 1'b0);
        acc(1'b0, disc, 16'h2EDF, 16'h0000, 16'h0001, 1'b0);
        acc(1'b0, disc, 16'h2EDE, 16'h0000, 16'h0000, 1'b0);
        acc(1'b1, hold, 16'h0800, 16'hFFFF, 16'h0000, 1'b1);
        acc(1'b0, hold, 16'h0AEE, 16'h0000, 16'h0000, 1'b1);
    endtask : map_in

    task automatic idle_check;
        acc(1'b1, hold, 16'h1004, 16'h0001, 16'h0000, 1'b0);
        chk("idle_mode", {15'h0000, idle_mode}, 16'h0001);
        acc(1'b0, hold, 16'h1004, 16'h0000, 16'h0001, 1'b0);
        acc(1'b1, hold, 16'h1004, 16'h0000, 16'h0000, 1'b0);
        chk("idle_mode", {15'h0000, idle_mode}, 16'h0000);
    endtask : idle_check

    // settle, then sample 12 cycles: steady lamps always lit, flashing ones sometimes
    task automatic watch(input logic [6:0] on, input logic [6:0] fl);
        logic [6:0] orv, andv;
        orv  = 7'h00;
        andv = 7'h7F;
        repeat (5) @(negedge clk);
        repeat (12) begin
            @(negedge clk);
            orv  = orv | lamps;
            andv = andv & lamps;
        end
        chk("lamps_lit", {9'h000, orv}, {9'h000, on | fl});
        chk("lamps_steady", {9'h000, andv}, {9'h000, on});
    endtask : watch

    task automatic lamps_server;
        st = 13'h184E;
        watch(7'h16, 7'h40);
        acc(1'b0, hold, 16'h0001, 16'h0000, 16'hA5C7, 1'b0);
        watch(7'h56, 7'h00);
    endtask : lamps_server

    task automatic lamps_table;
        logic [12:0] sv [5] = '{13'h1C6F, 13'h1A54, 13'h18CD, 13'h1948, 13'h0808};
        logic [6:0]  ov [5] = '{7'h24, 7'h01, 7'h28, 7'h00, 7'h04};
        logic [6:0]  fv [5] = '{7'h12, 7'h28, 7'h01, 7'h00, 7'h00};
        for (int i = 0; i < 5; i++) begin
            st = sv[i];
            watch(ov[i], fv[i]);
        end
    endtask : lamps_table

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        st = 13'h0000;
        sub_rd_idx = 10'h000;
        sub_wr_en = 1'b0;
        sub_wr_idx = 10'h000;
        sub_wr_data = 16'h0000;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        chk("idle_reset", {15'h0000, idle_mode}, 16'h0000);
        map_out();
        map_in();
        idle_check();
        lamps_server();
        lamps_table();
        end_sim();
    end
endmodule : test_gam_gateway
